// >>> rtl/sipm_pkg.sv
// Purpose: Shared constants and types for the serial pin-function mux.
// Assumes: One system clock at 125 MHz and one SPI link clock.
// Notes: Mode and function codes are shared by the mux and its crossing.
package sipm_pkg;

  // ---------------------------------------------------------------
  // SPI operating modes
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    SIPM_SPI_OFF    = 5'h01,
    SIPM_SPI_SINGLE = 5'h02,
    SIPM_SPI_DUAL   = 5'h04,
    SIPM_SPI_QUAD   = 5'h08,
    SIPM_SPI_SLAVE  = 5'h10
  } sipm_spi_mode_t;

  // ---------------------------------------------------------------
  // Multi-function pin selections
  // ---------------------------------------------------------------
  localparam logic [1:0] SIPM_FN_GPIO = 2'h0;
  localparam logic [1:0] SIPM_FN_ALT_A = 2'h1;
  localparam logic [1:0] SIPM_FN_ALT_B = 2'h2;

  // ---------------------------------------------------------------
  // Reset values, field positions and synchroniser depth
  // ---------------------------------------------------------------
  localparam logic [1:0] SIPM_FN_RST = 2'h0;
  localparam logic [1:0] SIPM_STRAP_RST = 2'h0;
  localparam int SIPM_STRAP_B0 = 0;
  localparam int SIPM_STRAP_B1 = 1;
  localparam int SIPM_SYNC_STAGES = 2;

endpackage

// >>> rtl/sipm_sync.sv
// Purpose: Two-flop synchroniser for a bundle of level signals.
// Assumes: Inputs are levels from another clock domain or a pad.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module sipm_sync import sipm_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// >>> rtl/sipm_mux.sv
// Purpose: Pad-side function mux for SPI, I2C and multi-function pins.
// Assumes: Config ports are static levels from the clk_sys domain.
// Notes: Pad outputs follow a combined mux held in flip-flops.
`timescale 1ns/1ps
module sipm_mux import sipm_pkg::*; (
  // System clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic main_rst_low,
  input wire logic test_mode_rst_low,
  // SPI link clock (slave mode)
  input wire logic spi_link_clk,
  // Configuration
  input wire sipm_spi_mode_t spi_mode,
  input wire logic i2c_enable,
  input wire logic [1:0] multi_fn_sel_0,
  input wire logic [1:0] multi_fn_sel_1,
  input wire logic [1:0] multi_fn_sel_2,
  input wire logic [1:0] multi_fn_sel_3,
  input wire logic charger_pol,
  // GPIO core side
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_dir,
  output logic [3:0] gpio_in,
  // SPI master core side
  input wire logic spi_sck_out,
  input wire logic [3:0] spi_dq_out,
  input wire logic [3:0] spi_dq_dir,
  input wire logic [3:0] spi_sel_out,
  output logic [3:0] spi_dq_in,
  // SPI slave core side, link domain
  input wire logic slave_miso_out,
  output logic slave_mosi_in,
  output logic slave_sel_low,
  // I2C core side
  input wire logic i2c_scl_pull,
  input wire logic i2c_sda_pull,
  output logic i2c_scl_in,
  output logic i2c_sda_in,
  // Power management side
  input wire logic usb_suspend,
  input wire logic charger_attached,
  output logic wakeup_req,
  output logic ext_interrupt_in,
  output logic [1:0] endpoint_cfg,
  // Pads
  input wire logic sck_pad_i,
  output logic sck_pad_o,
  output logic sck_pad_oe_n,
  input wire logic [3:0] dq_pad_i,
  output logic [3:0] dq_pad_o,
  output logic [3:0] dq_pad_oe_n,
  input wire logic [3:0] multi_pad_i,
  output logic [3:0] multi_pad_o,
  output logic [3:0] multi_pad_oe_n,
  output logic select_zero_out,
  input wire logic slave_sel_pad,
  input wire logic endpoint_cfg_strap_b0,
  input wire logic endpoint_cfg_strap_b1,
  output logic charger_detect_flag,
  input wire logic debug_pin_i,
  output logic debug_pin_o,
  output logic debug_pin_oe_n
);

  // ---------------------------------------------------------------
  // Reset combination
  // ---------------------------------------------------------------
  // Test reset is honoured too so a stray low cannot leave state stale.
  logic [1:0] rst_pins_s;
  logic slave_miso_s;
  logic slave_sel_s;
  wire rst_any = rst | rst_pins_s[0] | rst_pins_s[1];
  sipm_sync #(.W(2)) u_rst_sync (
    .clk(clk_sys),
    .rst(rst),
    .d({~test_mode_rst_low, ~main_rst_low}),
    .q(rst_pins_s)
  );

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  wire is_master = (spi_mode == SIPM_SPI_SINGLE) |
                   (spi_mode == SIPM_SPI_DUAL) |
                   (spi_mode == SIPM_SPI_QUAD);
  wire is_slave = (spi_mode == SIPM_SPI_SLAVE);
  wire is_wide = (spi_mode == SIPM_SPI_DUAL) | (spi_mode == SIPM_SPI_QUAD);
  wire is_quad = (spi_mode == SIPM_SPI_QUAD);

  function automatic logic alt_a(input logic [1:0] s);
    alt_a = (s == SIPM_FN_ALT_A);
  endfunction

  function automatic logic alt_b(input logic [1:0] s);
    alt_b = (s == SIPM_FN_ALT_B);
  endfunction

  // ---------------------------------------------------------------
  // SPI data and clock pads
  // ---------------------------------------------------------------
  wire sck_o_n = spi_sck_out;
  wire sck_oe_n_n = ~is_master;
  // Bit 1: input in single, bus in wide, output driven by slave.
  wire miso_o_n = is_slave ? slave_miso_s : spi_dq_out[1];
  wire miso_oe_n_n = is_slave ? slave_sel_s :
                     ~(is_wide & spi_dq_dir[1]);
  wire mosi_oe_n_n = ~(is_master & (~is_wide | spi_dq_dir[0]));
  wire q2_oe_n_n = ~(is_quad & spi_dq_dir[2]);
  wire q3_oe_n_n = ~(is_quad & spi_dq_dir[3]);
  wire [3:0] dq_oe_n_n = {q3_oe_n_n, q2_oe_n_n, miso_oe_n_n, mosi_oe_n_n};
  wire [3:0] dq_o_n = {spi_dq_out[3:2], miso_o_n, spi_dq_out[0]};

  // ---------------------------------------------------------------
  // Multi-function pads
  // ---------------------------------------------------------------
  wire ss1 = is_master & alt_a(multi_fn_sel_0);
  wire scl = i2c_enable & alt_b(multi_fn_sel_0);
  wire ss2 = is_master & alt_a(multi_fn_sel_1);
  wire sda = i2c_enable & alt_b(multi_fn_sel_1);
  wire ss3 = is_master & alt_a(multi_fn_sel_2);
  wire susp = alt_b(multi_fn_sel_2);
  wire wk = alt_a(multi_fn_sel_3);
  wire irq = alt_b(multi_fn_sel_3);
  wire [3:0] alt_on = {wk | irq, ss3 | susp, ss2 | sda, ss1 | scl};

  // I2C lines are open drain: drive low only, never high.
  wire m0_o = ss1 ? spi_sel_out[1] : scl ? 1'b0 : gpio_out[0];
  wire m0_oe = ss1 ? 1'b1 : scl ? i2c_scl_pull : gpio_dir[0];
  wire m1_o = ss2 ? spi_sel_out[2] : sda ? 1'b0 : gpio_out[1];
  wire m1_oe = ss2 ? 1'b1 : sda ? i2c_sda_pull : gpio_dir[1];
  wire m2_o = ss3 ? spi_sel_out[3] : susp ? usb_suspend : gpio_out[2];
  wire m2_oe = (ss3 | susp) ? 1'b1 : gpio_dir[2];
  wire m3_oe = alt_on[3] ? 1'b0 : gpio_dir[3];
  wire [3:0] multi_o_n = {gpio_out[3], m2_o, m1_o, m0_o};
  wire [3:0] multi_oe_n_n = ~{m3_oe, m2_oe, m1_oe, m0_oe};

  wire sel0_n = is_master ? spi_sel_out[0] : 1'b1;
  wire chg_n = charger_attached ^ ~charger_pol;

  // ---------------------------------------------------------------
  // Input synchronisers, system domain
  // ---------------------------------------------------------------
  logic [3:0] dq_s;
  logic [3:0] multi_s;
  logic [1:0] strap_s;
  sipm_sync #(.W(4)) u_dq_sync (
    .clk(clk_sys),
    .rst(rst_any),
    .d(dq_pad_i),
    .q(dq_s)
  );
  sipm_sync #(.W(4)) u_multi_sync (
    .clk(clk_sys),
    .rst(rst_any),
    .d(multi_pad_i),
    .q(multi_s)
  );
  // Straps keep syncing through a pin reset, so they are valid at capture.
  sipm_sync #(.W(2)) u_strap_sync (
    .clk(clk_sys),
    .rst(rst),
    .d({endpoint_cfg_strap_b1, endpoint_cfg_strap_b0}),
    .q(strap_s)
  );

  // ---------------------------------------------------------------
  // Slave link domain
  // ---------------------------------------------------------------
  // The slave core runs on the external clock; its miso and select
  // cross back into clk_sys for the pad registers.
  logic [1:0] slave_cfg_s;
  logic [1:0] slave_link_s;
  logic link_mosi_r;
  logic link_sel_r;
  sipm_sync #(.W(2)) u_cfg_link_sync (
    .clk(spi_link_clk),
    .rst(rst),
    .d({is_slave, 1'b0}),
    .q(slave_cfg_s)
  );
  always_ff @(posedge spi_link_clk or posedge rst) begin
    if (rst) begin
      link_mosi_r <= 1'b0;
      link_sel_r <= 1'b1;
    end else begin
      link_mosi_r <= dq_pad_i[0];
      link_sel_r <= slave_cfg_s[1] ? slave_sel_pad : 1'b1;
    end
  end
  assign slave_mosi_in = link_mosi_r;
  assign slave_sel_low = link_sel_r;

  sipm_sync #(.W(2)) u_link_back_sync (
    .clk(clk_sys),
    .rst(rst_any),
    .d({slave_miso_out, link_sel_r}),
    .q(slave_link_s)
  );
  assign slave_miso_s = slave_link_s[1];
  assign slave_sel_s = slave_link_s[0];

  // ---------------------------------------------------------------
  // Registered outputs, system domain
  // ---------------------------------------------------------------
  logic [2:0] strap_wait_r;
  always_ff @(posedge clk_sys or posedge rst_any) begin
    if (rst_any) begin
      sck_pad_o <= 1'b0;
      sck_pad_oe_n <= 1'b1;
      dq_pad_o <= '0;
      dq_pad_oe_n <= '1;
      multi_pad_o <= '0;
      multi_pad_oe_n <= '1;
      select_zero_out <= 1'b1;
      charger_detect_flag <= 1'b0;
      debug_pin_o <= 1'b1;
      debug_pin_oe_n <= 1'b1;
      endpoint_cfg <= SIPM_STRAP_RST;
      strap_wait_r <= '0;
      gpio_in <= '0;
      spi_dq_in <= '0;
      i2c_scl_in <= 1'b1;
      i2c_sda_in <= 1'b1;
      wakeup_req <= 1'b0;
      ext_interrupt_in <= 1'b0;
    end else begin
      sck_pad_o <= sck_o_n;
      sck_pad_oe_n <= sck_oe_n_n;
      dq_pad_o <= dq_o_n;
      dq_pad_oe_n <= dq_oe_n_n;
      multi_pad_o <= multi_o_n;
      multi_pad_oe_n <= multi_oe_n_n;
      select_zero_out <= sel0_n;
      charger_detect_flag <= chg_n;
      debug_pin_o <= 1'b1;
      debug_pin_oe_n <= 1'b1;
      // Straps are caught for three edges after release, covering the
      // synchroniser delay after a full reset, then held.
      strap_wait_r <= {strap_wait_r[1:0], 1'b1};
      if (!strap_wait_r[2]) begin
        endpoint_cfg <= {strap_s[SIPM_STRAP_B1], strap_s[SIPM_STRAP_B0]};
      end
      gpio_in <= multi_s & ~alt_on;
      spi_dq_in <= is_master ? dq_s : 4'h0;
      i2c_scl_in <= scl ? multi_s[0] : 1'b1;
      i2c_sda_in <= sda ? multi_s[1] : 1'b1;
      wakeup_req <= wk & ~multi_s[3];
      ext_interrupt_in <= irq & multi_s[3];
    end
  end

endmodule

// >>> test/sipm_mux_properties.sv
// Purpose: Port-level properties of the serial pin-function mux.
// Assumes: Config and core inputs change only on clk_sys edges.
// Notes: Quiet for five edges after any reset, so the sync delay settles.
`timescale 1ns/1ps
module sipm_mux_properties import sipm_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic main_rst_low,
  input wire logic test_mode_rst_low,
  input wire sipm_spi_mode_t spi_mode,
  input wire logic i2c_enable,
  input wire logic [1:0] multi_fn_sel_0,
  input wire logic [1:0] multi_fn_sel_2,
  input wire logic charger_pol,
  input wire logic spi_sck_out,
  input wire logic [3:0] spi_dq_out,
  input wire logic [3:0] spi_dq_dir,
  input wire logic [3:0] spi_sel_out,
  input wire logic i2c_scl_pull,
  input wire logic usb_suspend,
  input wire logic charger_attached,
  input wire logic [1:0] endpoint_cfg,
  input wire logic sck_pad_o,
  input wire logic sck_pad_oe_n,
  input wire logic [3:0] dq_pad_o,
  input wire logic [3:0] dq_pad_oe_n,
  input wire logic [3:0] multi_pad_o,
  input wire logic [3:0] multi_pad_oe_n,
  input wire logic select_zero_out,
  input wire logic charger_detect_flag
);
  logic [4:0] quiet_r;
  wire rst_any = rst | !main_rst_low | !test_mode_rst_low;
  wire is_master = spi_mode inside {SIPM_SPI_SINGLE, SIPM_SPI_DUAL,
                                    SIPM_SPI_QUAD};
  // The pin resets reach the registers only after a two-flop delay.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      quiet_r <= 5'h1f;
    end else begin
      quiet_r <= {quiet_r[3:0], rst_any};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst || (|quiet_r));
  AST_SCK_OUT: assert property (
    is_master |=> !sck_pad_oe_n && sck_pad_o == $past(spi_sck_out))
    else $error("clock pad not driven in master mode");
  AST_SLAVE_IN: assert property (
    spi_mode == SIPM_SPI_SLAVE |=> sck_pad_oe_n && dq_pad_oe_n[0])
    else $error("clock or mosi pad driven in slave mode");
  AST_MISO_IN: assert property (
    spi_mode == SIPM_SPI_SINGLE |=> dq_pad_oe_n[1])
    else $error("miso pad driven in single mode");
  AST_MOSI_OUT: assert property (
    spi_mode == SIPM_SPI_SINGLE |=> !dq_pad_oe_n[0] &&
      dq_pad_o[0] == $past(spi_dq_out[0]))
    else $error("mosi pad wrong in single mode");
  AST_QUAD_DIR: assert property (
    spi_mode == SIPM_SPI_QUAD |=> dq_pad_oe_n == ~$past(spi_dq_dir))
    else $error("quad pad direction wrong");
  AST_SEL_ZERO: assert property (
    1'b1 |=> select_zero_out ==
      ($past(is_master) ? $past(spi_sel_out[0]) : 1'b1))
    else $error("select zero wrong");
  AST_SUSPEND: assert property (
    multi_fn_sel_2 == SIPM_FN_ALT_B |=> !multi_pad_oe_n[2] &&
      multi_pad_o[2] == $past(usb_suspend))
    else $error("suspend indicator wrong");
  AST_SCL_PULL: assert property (
    multi_fn_sel_0 == SIPM_FN_ALT_B && i2c_enable |=>
      multi_pad_oe_n[0] == !$past(i2c_scl_pull))
    else $error("i2c clock pad wrong");
  AST_CHARGER: assert property (
    1'b1 |=> charger_detect_flag ==
      ($past(charger_attached) ~^ $past(charger_pol)))
    else $error("charger flag wrong");
  AST_STRAP: assert property (
    1'b1 |=> $stable(endpoint_cfg))
    else $error("endpoint code moved after reset");
endmodule
bind sipm_mux sipm_mux_properties u_props (.*);

// >>> test/sipm_board_model.sv
// Purpose: Board and far-side peers around the mux pads.
// Assumes: Peer values come from the bench.
// Notes: Multi pins are wired-AND with a pull-up, as for I2C.
`timescale 1ns/1ps
module sipm_board_model import sipm_pkg::*; (
  // Mux side
  input wire sipm_spi_mode_t spi_mode,
  input wire logic spi_link_clk,
  input wire logic sck_pad_o,
  input wire logic sck_pad_oe_n,
  input wire logic [3:0] dq_pad_o,
  input wire logic [3:0] dq_pad_oe_n,
  input wire logic [3:0] multi_pad_o,
  input wire logic [3:0] multi_pad_oe_n,
  input wire logic debug_pin_o,
  input wire logic debug_pin_oe_n,
  // Peer drive
  input wire logic [3:0] peer_dq,
  input wire logic [3:0] peer_multi,
  input wire logic peer_sel_low,
  input wire logic [1:0] strap,
  // Pads seen by the mux
  output logic sck_pad_i,
  output logic [3:0] dq_pad_i,
  output logic [3:0] multi_pad_i,
  output logic slave_sel_pad,
  output logic endpoint_cfg_strap_b0,
  output logic endpoint_cfg_strap_b1,
  output logic test_mode_rst_low,
  output logic debug_pin_i
);
  wire is_master = spi_mode inside {SIPM_SPI_SINGLE, SIPM_SPI_DUAL,
                                    SIPM_SPI_QUAD};
  assign sck_pad_i = sck_pad_oe_n ? spi_link_clk : sck_pad_o;
  assign dq_pad_i = (dq_pad_oe_n & peer_dq) | (~dq_pad_oe_n & dq_pad_o);
  assign multi_pad_i = (multi_pad_o | multi_pad_oe_n) & peer_multi;
  assign slave_sel_pad = is_master | peer_sel_low;
  assign endpoint_cfg_strap_b0 = strap[0];
  assign endpoint_cfg_strap_b1 = strap[1];
  assign test_mode_rst_low = 1'b1;
  assign debug_pin_i = debug_pin_oe_n | debug_pin_o;
endmodule

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the pin-function mux.
// Assumes: Board model closes every pad loop.
// Notes: Link clock runs only inside t_slave, from before slave mode is set until after the frame ends.
`timescale 1ns/1ps
module tb_top import sipm_pkg::*;;
  logic clk_sys = 0, rst = 1, main_rst_low = 1, spi_link_clk = 0;
  logic link_run = 0, i2c_enable = 0, charger_pol = 1, spi_sck_out = 1;
  logic slave_miso_out = 0, i2c_scl_pull = 0, i2c_sda_pull = 0;
  logic usb_suspend = 0, charger_attached = 0, peer_sel_low = 1;
  sipm_spi_mode_t spi_mode = SIPM_SPI_OFF;
  logic [1:0] multi_fn_sel_0 = 2'h0, multi_fn_sel_1 = 2'h0;
  logic [1:0] multi_fn_sel_2 = 2'h0, multi_fn_sel_3 = 2'h0, strap = 2'h2;
  logic [3:0] gpio_out = 4'h1, gpio_dir = 4'h3, spi_dq_out = 4'ha;
  logic [3:0] spi_dq_dir = 4'h6, spi_sel_out = 4'h4, peer_dq = 4'h6;
  logic [3:0] peer_multi = 4'hb;
  wire test_mode_rst_low, sck_pad_i, sck_pad_o, sck_pad_oe_n;
  wire slave_mosi_in, slave_sel_low, i2c_scl_in, i2c_sda_in, wakeup_req;
  wire ext_interrupt_in, select_zero_out, slave_sel_pad, debug_pin_i;
  wire endpoint_cfg_strap_b0, endpoint_cfg_strap_b1, charger_detect_flag;
  wire debug_pin_o, debug_pin_oe_n;
  wire [3:0] gpio_in, spi_dq_in, dq_pad_i, dq_pad_o, dq_pad_oe_n;
  wire [3:0] multi_pad_i, multi_pad_o, multi_pad_oe_n;
  wire [1:0] endpoint_cfg;
  int mismatches = 0, checks = 0;
  sipm_mux dut (.*);
  sipm_board_model u_board (.*);
  always #4 clk_sys = ~clk_sys;
  initial begin
    #3;
    forever #16 spi_link_clk = link_run & ~spi_link_clk;
  end
  task automatic chk(string n, logic [3:0] e, logic [3:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task t_reset;
    chk("strap", 4'h2, {2'h0, endpoint_cfg});
    chk("sel0 off", 4'h1, {3'h0, select_zero_out});
    @(posedge clk_sys) spi_mode <= SIPM_SPI_SINGLE;
    spi_sel_out <= 4'h0;
    cyc(3);
    chk("sel0 on", 4'h0, {3'h0, select_zero_out});
    @(posedge clk_sys) main_rst_low <= 1'b0;
    cyc(5);
    chk("rst", 4'h3, {2'h0, select_zero_out, sck_pad_oe_n});
    @(posedge clk_sys) main_rst_low <= 1'b1;
    cyc(8);
    chk("after rst", 4'h0, {2'h0, select_zero_out, sck_pad_oe_n});
  endtask
  task t_master;
    sipm_spi_mode_t md[3] = '{SIPM_SPI_SINGLE, SIPM_SPI_DUAL, SIPM_SPI_QUAD};
    logic [3:0] oe[3] = '{4'he, 4'hd, 4'h9};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys) spi_mode <= md[i];
      cyc(6);
      chk("sck oe", 4'h0, {3'h0, sck_pad_oe_n});
      chk("dq oe", oe[i], dq_pad_oe_n);
      chk("dq in", (oe[i] & peer_dq) | (~oe[i] & spi_dq_out),
          spi_dq_in);
    end
  endtask
  task t_slave;
    @(posedge clk_sys) spi_mode <= SIPM_SPI_OFF;
    peer_sel_low <= 1'b0;
    link_run <= 1'b1;
    peer_dq <= 4'h1;
    slave_miso_out <= 1'b1;
    cyc(12);
    chk("sel off", 4'h1, {3'h0, slave_sel_low});
    @(posedge clk_sys) spi_mode <= SIPM_SPI_SLAVE;
    cyc(16);
    chk("slave in", 4'h2, {2'h0, slave_mosi_in, slave_sel_low});
    chk("miso", 4'h7, {dq_pad_oe_n[1:0], dq_pad_o[1], sck_pad_oe_n});
    @(posedge clk_sys) peer_sel_low <= 1'b1;
    cyc(16);
    chk("miso off", 4'h1, {3'h0, dq_pad_oe_n[1]});
    @(posedge clk_sys) link_run <= 1'b0;
  endtask
  task t_multi;
    cyc(8);
    chk("gpio oe", 4'hc, multi_pad_oe_n);
    chk("gpio in", 4'h9, gpio_in);
    @(posedge clk_sys) spi_mode <= SIPM_SPI_SINGLE;
    {multi_fn_sel_0, multi_fn_sel_1} <= {2{SIPM_FN_ALT_A}};
    {multi_fn_sel_2, multi_fn_sel_3} <= {2{SIPM_FN_ALT_A}};
    {gpio_dir, spi_sel_out, peer_multi} <= {4'hf, 4'h5, 4'h7};
    cyc(8);
    chk("alt a oe", 4'h8, multi_pad_oe_n);
    chk("alt a out", 4'h2, {1'b0, multi_pad_o[2:0]});
    chk("alt a in", 4'h8, {wakeup_req, gpio_in[2:0]});
    @(posedge clk_sys) {multi_fn_sel_0, multi_fn_sel_1} <= {2{SIPM_FN_ALT_B}};
    {multi_fn_sel_2, multi_fn_sel_3} <= {2{SIPM_FN_ALT_B}};
    {i2c_enable, usb_suspend, i2c_scl_pull, peer_multi} <= {3'h7, 4'hd};
    cyc(8);
    chk("alt b oe", 4'ha, multi_pad_oe_n);
    chk("alt b in", 4'hc, {multi_pad_o[2], ext_interrupt_in,
        i2c_sda_in, i2c_scl_in});
  endtask
  task t_charger;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys) {charger_pol, charger_attached} <= i[1:0];
      cyc(3);
      chk("charger", {3'h0, i[1] ~^ i[0]}, {3'h0, charger_detect_flag});
    end
  endtask
  initial begin
    #200000;
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(8);
    t_reset;
    t_master;
    t_slave;
    @(posedge clk_sys) {spi_mode, peer_multi} <= {SIPM_SPI_OFF, 4'hb};
    {gpio_dir, gpio_out} <= {4'h3, 4'h1};
    t_multi;
    t_charger;
    end_sim;
  end
endmodule
